/* File: design/sdli_frame_monitor.sv */
// sdli_frame_monitor: counts consecutive bad-crc frames and message bytes
// and raises one-cycle failure and oversize events.
// assumes frame and byte strobes are one-cycle pulses in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module sdli_frame_monitor
    import sdli_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic thresh_sel,
    input wire logic frame_done,
    input wire logic frame_crc_bad,
    input wire logic msg_byte,
    input wire logic msg_end,
    output logic crc_fail_evt,
    output logic oversize_evt,
    output logic [CRC_CNT_W-1:0] bad_count
);

    logic [CRC_CNT_W-1:0] limit;
    logic [LEN_W-1:0] byte_count;

    assign limit = thresh_sel ? CRC_THRESH_HIGH : CRC_THRESH_LOW; // [R2]

    // counter saturates at the limit so the event fires once per run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bad_count <= '0;
            crc_fail_evt <= 1'b0;
        end else if (ce) begin
            crc_fail_evt <= 1'b0;
            if (frame_done) begin
                if (!frame_crc_bad) begin
                    bad_count <= '0;
                end else if (bad_count < limit) begin
                    bad_count <= bad_count + 1'b1;
                    crc_fail_evt <= (bad_count + 1'b1) == limit; // [R1]
                end
            end
        end
    end

    // event on the first byte past the limit; a byte with msg_end still counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_count <= '0;
            oversize_evt <= 1'b0;
        end else if (ce) begin
            oversize_evt <= msg_byte && (byte_count == MSG_MAX_BYTES); // [R4]
            if (msg_end) begin
                byte_count <= '0;
            end else if (msg_byte && byte_count <= MSG_MAX_BYTES) begin
                byte_count <= byte_count + 1'b1;
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_crc_fail_reach: assert property ( // [R1]
        ce && frame_done && frame_crc_bad && (bad_count == limit - 1'b1)
        |=> crc_fail_evt
    ) else $error("failure event missing at crc threshold");

    a_oversize_byte: assert property ( // [R4]
        oversize_evt && $past(ce) |-> $past(msg_byte) && $past(byte_count) == MSG_MAX_BYTES
    ) else $error("oversize event without 277th byte");

endmodule
`default_nettype wire

/* File: design/sdli_pkg.sv */
// sdli_pkg: register map, field positions, reset values and counts for
// the signaling data link interrupt block.
// assumes AXI4-Lite with 32-bit data, one register per aligned word.
package sdli_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_SS7_ENABLE = 8'h00;
    localparam logic [7:0] OFF_SS7_STATUS = 8'h04;
    localparam logic [7:0] OFF_DL3_STATUS = 8'h08;
    localparam logic [7:0] OFF_DL3_MASK = 8'h0C;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_CRC_COUNT = 8'h14;

    // ss7 enable / status layout (same positions in both)
    localparam int SS7_TX_START_BIT = 5;
    localparam int SS7_RX_START_BIT = 4;
    localparam int SS7_TX_END_BIT = 3;
    localparam int SS7_RX_END_BIT = 2;
    localparam int SS7_CRC_FAIL_BIT = 1;
    localparam int SS7_OVERSIZE_BIT = 0;
    localparam int SS7_W = 6;

    // third controller status / mask layout
    localparam int DL3_KIND_BIT = 7;
    localparam int DL3_TX_START_BIT = 6;
    localparam int DL3_RX_START_BIT = 5;
    localparam int DL3_TX_END_BIT = 4;
    localparam int DL3_FLAG_LSB = 4;
    localparam int DL3_W = 3;

    localparam int CTRL_THRESH_SEL_BIT = 0;

    localparam logic [SS7_W-1:0] SS7_ENABLE_RST = 6'h00;
    localparam logic [DL3_W-1:0] DL3_MASK_RST = 3'h0;
    localparam logic [DL3_W-1:0] DL3_FLAGS_RST = 3'h0;

    // consecutive bad-crc frame thresholds and oversize limit
    localparam int CRC_CNT_W = 7;
    localparam logic [CRC_CNT_W-1:0] CRC_THRESH_LOW = 7'h20;
    localparam logic [CRC_CNT_W-1:0] CRC_THRESH_HIGH = 7'h40;
    localparam int LEN_W = 9;
    localparam logic [LEN_W-1:0] MSG_MAX_BYTES = 9'h114;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/sdli_top.sv */
// sdli_top: interrupt enable and status registers for the ss7 link of the
// second controller and the upper status half of the third controller.
// assumes AXI4-Lite master on aclk; event inputs are one-cycle pulses.
//
// Summary of operation
// R1: crc failure event fires when bad-crc counter reaches threshold
// R2: threshold selectable as 32 or 64 consecutive bad-crc frames
// R3: enable bit 1 gates the failure interrupt, resets to 0
// R4: oversize event fires when a received message exceeds 276 bytes
// R5: enable bit 0 gates the oversize interrupt, resets to 0
// R6: enable bits 5 and 3 gate transmit start and end interrupts
// R7: enable bits 4 and 2 gate receive start and end interrupts
// R8: third-controller status bit 7 shows received message kind, read only
// R9: status bit 6 sets when the transmitter starts a message
// R10: software fills next transmit buffer upon transmit-start event
// R11: status bit 5 sets when the receiver starts a message
// R12: status bit 4 sets when transmission of a message ends
// R13: software loads next transmit buffer before the transmit-end event
// R14: start and end status bits clear when the status register is read
// R15: failure and oversize bits live in companion status, clear on read
// R16: interrupt asserts only while an enabled status bit is set
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdli_top
    import sdli_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic ss7_tx_start,
    input wire logic ss7_rx_start,
    input wire logic ss7_tx_end,
    input wire logic ss7_rx_end,
    input wire logic ss7_frame_done,
    input wire logic ss7_frame_crc_bad,
    input wire logic ss7_msg_byte,
    input wire logic ss7_msg_end,
    input wire logic dl3_tx_start,
    input wire logic dl3_rx_start,
    input wire logic dl3_tx_end,
    input wire logic dl3_msg_kind,
    output logic irq
);

    logic [SS7_W-1:0] ss7_enable;
    logic [SS7_W-1:0] ss7_flags;
    logic [SS7_W-1:0] ss7_set;
    logic [SS7_W-1:0] ss7_clr;
    logic [DL3_W-1:0] dl3_mask;
    logic [DL3_W-1:0] dl3_flags;
    logic [DL3_W-1:0] dl3_set;
    logic [DL3_W-1:0] dl3_clr;
    logic received_message_kind;
    logic thresh_sel;
    logic crc_fail_evt;
    logic oversize_evt;
    logic [CRC_CNT_W-1:0] bad_count;

    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic ar_fire;
    logic [ADDR_W-1:0] ar_word;
    logic [ADDR_W-1:0] aw_word;
    logic wr_lane0;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;
    logic wr_hit;

    sdli_frame_monitor u_monitor (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .thresh_sel(thresh_sel),
        .frame_done(ss7_frame_done),
        .frame_crc_bad(ss7_frame_crc_bad),
        .msg_byte(ss7_msg_byte),
        .msg_end(ss7_msg_end),
        .crc_fail_evt(crc_fail_evt),
        .oversize_evt(oversize_evt),
        .bad_count(bad_count)
    );

    // write channel: address and data taken independently, in either order
    assign awready = ce && !aw_full;
    assign wready = ce && !w_full;
    assign wr_go = aw_full && w_full && !bvalid;
    assign aw_word = {aw_addr[ADDR_W-1:2], 2'b00};
    assign wr_lane0 = wr_go && w_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_full <= 1'b1;
                aw_addr <= awaddr;
            end else if (wr_go) begin
                aw_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (wvalid && wready) begin
                w_full <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end else if (wr_go) begin
                w_full <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_hit = 1'b0;
        case (aw_word)
            OFF_SS7_ENABLE, OFF_SS7_STATUS, OFF_DL3_STATUS, OFF_DL3_MASK,
            OFF_CONTROL, OFF_CRC_COUNT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, data registered at the ar edge
    assign arready = ce && !rvalid;
    assign ar_fire = arvalid && arready;
    assign ar_word = {araddr[ADDR_W-1:2], 2'b00};

    always_comb begin
        next_rdata = '0;
        next_rresp = RESP_OKAY;
        case (ar_word)
            OFF_SS7_ENABLE: next_rdata[SS7_W-1:0] = ss7_enable;
            OFF_SS7_STATUS: next_rdata[SS7_W-1:0] = ss7_flags;
            OFF_DL3_STATUS: begin
                next_rdata[DL3_KIND_BIT] = received_message_kind; // [R8]
                next_rdata[DL3_FLAG_LSB +: DL3_W] = dl3_flags;
            end
            OFF_DL3_MASK: next_rdata[DL3_FLAG_LSB +: DL3_W] = dl3_mask;
            OFF_CONTROL: next_rdata[CTRL_THRESH_SEL_BIT] = thresh_sel;
            OFF_CRC_COUNT: next_rdata[CRC_CNT_W-1:0] = bad_count;
            default: next_rresp = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                rvalid <= 1'b1;
                rdata <= next_rdata;
                rresp <= next_rresp;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // software-written control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ss7_enable <= SS7_ENABLE_RST; // [R3] [R5]
            dl3_mask <= DL3_MASK_RST;
            thresh_sel <= 1'b0;
        end else if (ce && wr_lane0) begin
            if (aw_word == OFF_SS7_ENABLE) begin
                ss7_enable <= w_data[SS7_W-1:0]; // [R6] [R7]
            end
            if (aw_word == OFF_DL3_MASK) begin
                dl3_mask <= w_data[DL3_FLAG_LSB +: DL3_W];
            end
            if (aw_word == OFF_CONTROL) begin
                thresh_sel <= w_data[CTRL_THRESH_SEL_BIT]; // [R2]
            end
        end
    end

    // sticky flags: read clears all, write-one clears chosen bits; set wins
    always_comb begin
        ss7_set = '0;
        ss7_set[SS7_TX_START_BIT] = ss7_tx_start;
        ss7_set[SS7_RX_START_BIT] = ss7_rx_start;
        ss7_set[SS7_TX_END_BIT] = ss7_tx_end;
        ss7_set[SS7_RX_END_BIT] = ss7_rx_end;
        ss7_set[SS7_CRC_FAIL_BIT] = crc_fail_evt; // [R1]
        ss7_set[SS7_OVERSIZE_BIT] = oversize_evt; // [R4]
        dl3_set = '0;
        dl3_set[DL3_TX_START_BIT-DL3_FLAG_LSB] = dl3_tx_start; // [R9]
        dl3_set[DL3_RX_START_BIT-DL3_FLAG_LSB] = dl3_rx_start; // [R11]
        dl3_set[DL3_TX_END_BIT-DL3_FLAG_LSB] = dl3_tx_end; // [R12]
        ss7_clr = '0;
        dl3_clr = '0;
        if (ar_fire && ar_word == OFF_SS7_STATUS) begin
            ss7_clr = '1; // [R15]
        end
        if (ar_fire && ar_word == OFF_DL3_STATUS) begin
            dl3_clr = '1; // [R14]
        end
        if (wr_lane0 && aw_word == OFF_SS7_STATUS) begin
            ss7_clr = ss7_clr | w_data[SS7_W-1:0];
        end
        if (wr_lane0 && aw_word == OFF_DL3_STATUS) begin
            dl3_clr = dl3_clr | w_data[DL3_FLAG_LSB +: DL3_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ss7_flags <= '0;
        end else if (ce) begin
            ss7_flags <= (ss7_flags & ~ss7_clr) | ss7_set; // [R14] [R15]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dl3_flags <= DL3_FLAGS_RST;
        end else if (ce) begin
            dl3_flags <= (dl3_flags & ~dl3_clr) | dl3_set; // [R14]
        end
    end

    // kind is latched as each message starts arriving
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            received_message_kind <= 1'b0;
        end else if (ce && dl3_rx_start) begin
            received_message_kind <= dl3_msg_kind; // [R8]
        end
    end

    // level output; drops as soon as the read clears the last enabled flag
    assign irq = |(ss7_flags & ss7_enable) || |(dl3_flags & dl3_mask); // [R16] [R3] [R5]

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_read_ss7;
        ar_fire && ar_word == OFF_SS7_STATUS && ss7_set == '0;
    endsequence

    sequence s_read_dl3;
        ar_fire && ar_word == OFF_DL3_STATUS && dl3_set == '0;
    endsequence

    a_fail_gated: assert property ( // [R3]
        ss7_flags[SS7_CRC_FAIL_BIT] && !ss7_enable[SS7_CRC_FAIL_BIT]
        && (ss7_flags & ss7_enable) == '0 && (dl3_flags & dl3_mask) == '0 |-> !irq
    ) else $error("irq from disabled failure flag");

    a_fail_raises_irq: assert property ( // [R1] [R3]
        ce && crc_fail_evt && ss7_enable[SS7_CRC_FAIL_BIT] && !wr_go |=> irq
    ) else $error("enabled failure event gave no irq");

    a_oversize_irq: assert property ( // [R5]
        ce && oversize_evt && ss7_enable[SS7_OVERSIZE_BIT] && !wr_go |=> irq
    ) else $error("enabled oversize event gave no irq");

    a_tx_pair_irq: assert property ( // [R6]
        ce && (ss7_tx_start && ss7_enable[SS7_TX_START_BIT]
        || ss7_tx_end && ss7_enable[SS7_TX_END_BIT]) && !wr_go |=> irq
    ) else $error("transmit event enabled but no irq");

    a_rx_pair_irq: assert property ( // [R7]
        ce && (ss7_rx_start && ss7_enable[SS7_RX_START_BIT]
        || ss7_rx_end && ss7_enable[SS7_RX_END_BIT]) && !wr_go |=> irq
    ) else $error("receive event enabled but no irq");

    a_kind_capture: assert property ( // [R8]
        ce && dl3_rx_start |=> received_message_kind == $past(dl3_msg_kind)
    ) else $error("message kind not captured");

    a_dl3_sets: assert property ( // [R9] [R11] [R12]
        ce && (dl3_tx_start || dl3_rx_start || dl3_tx_end)
        |=> (dl3_flags & $past(dl3_set)) == $past(dl3_set)
    ) else $error("third controller flag did not set");

    a_dl3_read_clear: assert property ( // [R14]
        s_read_dl3 |=> dl3_flags == '0 && rvalid
    ) else $error("third controller status not cleared by read");

    a_ss7_read_clear: assert property ( // [R15]
        s_read_ss7 ##1 (ss7_set == '0 || !ce) |=> ss7_flags == '0
    ) else $error("ss7 status not cleared by read");

    a_irq_needs_flag: assert property ( // [R16]
        irq |-> (ss7_flags & ss7_enable) != '0 || (dl3_flags & dl3_mask) != '0
    ) else $error("irq without enabled flag");

    a_read_answer: assert property (
        ar_fire |=> rvalid && rdata == $past(next_rdata)
    ) else $error("read answer late or wrong");

endmodule
`default_nettype wire

/* File: sim/sdli_top_tb.sv */
// sdli_top_tb: self-checking bench for the signaling data link interrupt block.
// assumes sdli_pkg is compiled first; the bench alone plays the AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module sdli_top_tb
    import sdli_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [6:0] ev;
    logic frame_done, crc_bad, msg_byte, msg_end, kind;
    int bad_count = 0;
    int num_checks = 0;

    sdli_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .ss7_tx_start(ev[0]), .ss7_rx_start(ev[1]), .ss7_tx_end(ev[2]),
        .ss7_rx_end(ev[3]), .ss7_frame_done(frame_done), .ss7_frame_crc_bad(crc_bad),
        .ss7_msg_byte(msg_byte), .ss7_msg_end(msg_end), .dl3_tx_start(ev[4]),
        .dl3_rx_start(ev[5]), .dl3_tx_end(ev[6]), .dl3_msg_kind(kind), .irq(irq));

    always #4 aclk = ~aclk;

    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // address and data offered together, each dropped once its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        bit a_ok;
        bit w_ok;
        n = 0;
        a_ok = 0;
        w_ok = 0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        do begin
            @(posedge aclk);
            n++;
            if (!a_ok && awready === 1'b1) begin
                a_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end while (!(a_ok && w_ok) && n < 100);
        while (bvalid !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        r = bresp;
        if (n >= 200) chk("write timeout", 32'h1, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr <= a;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 200);
        d = rdata;
        r = rresp;
        if (n >= 200) chk("read timeout", 32'h1, 32'h0);
    endtask

    // one-cycle event, then an extra edge so the flag has landed
    task automatic pulse(input int i);
        @(posedge aclk);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev[i] <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic frames(input int n, input logic bad);
        repeat (n) begin
            @(posedge aclk);
            frame_done <= 1'b1;
            crc_bad <= bad;
            @(posedge aclk);
            frame_done <= 1'b0;
        end
        repeat (2) @(posedge aclk);
    endtask

    task automatic msg(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge aclk);
            msg_byte <= 1'b1;
            msg_end <= (k == n - 1);
            @(posedge aclk);
            msg_byte <= 1'b0;
            msg_end <= 1'b0;
        end
        repeat (3) @(posedge aclk);
    endtask

    task automatic t_reset_map();
        logic [7:0] offs [6];
        offs = '{OFF_SS7_ENABLE, OFF_SS7_STATUS, OFF_DL3_STATUS, OFF_DL3_MASK, OFF_CONTROL,
                 OFF_CRC_COUNT};
        foreach (offs[k]) begin
            rd(offs[k]);
            chk("reset value", d, 32'h0);
            chk("reset resp", {30'h0, r}, {30'h0, RESP_OKAY});
        end
        chk("irq after reset", {31'h0, irq}, 32'h0);
        wr(OFF_SS7_ENABLE, 32'h000000FF);
        rd(OFF_SS7_ENABLE);
        chk("enable rw", d, 32'h0000003F);
        wr(8'h18, 32'h000000FF);
        chk("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
        rd(8'h18);
        chk("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
    endtask

    task automatic t_ss7_events();
        for (int i = 0; i < 4; i++) begin
            wr(OFF_SS7_ENABLE, 32'h1 << (5 - i));
            pulse(i);
            chk("ss7 irq set", {31'h0, irq}, 32'h1);
            rd(OFF_SS7_STATUS);
            chk("ss7 status", d, 32'h1 << (5 - i));
            chk("ss7 irq clear", {31'h0, irq}, 32'h0);
            rd(OFF_SS7_STATUS);
            chk("ss7 read clears", d, 32'h0);
        end
        wr(OFF_SS7_ENABLE, 32'h0000001F);
        pulse(0);
        chk("masked event irq", {31'h0, irq}, 32'h0);
        wr(OFF_SS7_STATUS, 32'h00000020);
        rd(OFF_SS7_STATUS);
        chk("ss7 w1c", d, 32'h0);
    endtask

    // an event offered while ce is low is not taken; one after thaw is
    task automatic t_freeze();
        wr(OFF_SS7_ENABLE, 32'h00000020);
        @(posedge aclk);
        ce <= 1'b0;
        ev[0] <= 1'b1;
        @(posedge aclk);
        ev[0] <= 1'b0;
        @(posedge aclk);
        chk("frozen event irq", {31'h0, irq}, 32'h0);
        chk("frozen arready", {31'h0, arready}, 32'h0);
        ce <= 1'b1;
        pulse(0);
        chk("event after thaw", {31'h0, irq}, 32'h1);
        rd(OFF_SS7_STATUS);
        chk("thaw status", d, 32'h00000020);
    endtask

    task automatic t_crc_fail();
        wr(OFF_SS7_ENABLE, 32'h00000002);
        frames(31, 1'b1);
        rd(OFF_CRC_COUNT);
        chk("bad count 31", d, 32'h1F);
        frames(1, 1'b0);
        rd(OFF_CRC_COUNT);
        chk("good frame resets", d, 32'h0);
        frames(31, 1'b1);
        chk("no irq below 32", {31'h0, irq}, 32'h0);
        frames(1, 1'b1);
        chk("irq at 32", {31'h0, irq}, 32'h1);
        rd(OFF_SS7_STATUS);
        chk("fail flag", d, 32'h2);
        frames(1, 1'b1);
        rd(OFF_SS7_STATUS);
        chk("one event per run", d, 32'h0);
        wr(OFF_CONTROL, 32'h1);
        frames(1, 1'b0);
        frames(63, 1'b1);
        rd(OFF_SS7_STATUS);
        chk("no flag at 63", d, 32'h0);
        frames(1, 1'b1);
        rd(OFF_SS7_STATUS);
        chk("flag at 64", d, 32'h2);
        wr(OFF_SS7_ENABLE, 32'h0);
        frames(1, 1'b0);
    endtask

    task automatic t_oversize();
        wr(OFF_SS7_ENABLE, 32'h00000001);
        msg(276);
        chk("no irq at 276", {31'h0, irq}, 32'h0);
        rd(OFF_SS7_STATUS);
        chk("no oversize 276", d, 32'h0);
        msg(277);
        chk("irq at 277", {31'h0, irq}, 32'h1);
        rd(OFF_SS7_STATUS);
        chk("oversize flag", d, 32'h1);
        chk("irq after read", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_dl3();
        logic [31:0] bit_v;
        for (int i = 4; i < 7; i++) begin
            bit_v = 32'h1 << (10 - i);
            wr(OFF_DL3_MASK, bit_v);
            // software sees each transmit start before the matching end arrives
            pulse(i);
            chk("dl3 irq", {31'h0, irq}, 32'h1);
            rd(OFF_DL3_STATUS);
            chk("dl3 status", d, bit_v | ((i >= 5) ? 32'h80 : 32'h0));
            rd(OFF_DL3_STATUS);
            chk("dl3 read clears", d, (i >= 5) ? 32'h80 : 32'h0);
        end
        pulse(6);
        wr(OFF_DL3_STATUS, 32'h00000090);
        rd(OFF_DL3_STATUS);
        chk("kind read only", d, 32'h80);
        kind <= 1'b0;
        pulse(5);
        rd(OFF_DL3_STATUS);
        chk("kind bit oriented", d, 32'h20);
    endtask

    initial begin
        aresetn <= 1'b0;
        ce <= 1'b1;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        arvalid <= 1'b0;
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0;
        wstrb <= 4'hF;
        bready <= 1'b1;
        rready <= 1'b1;
        ev <= 7'h00;
        frame_done <= 1'b0;
        crc_bad <= 1'b0;
        msg_byte <= 1'b0;
        msg_end <= 1'b0;
        kind <= 1'b1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_map();
        t_ss7_events();
        t_freeze();
        t_crc_fail();
        t_oversize();
        t_dl3();
        print_verdict();
    end

    // whole run is under two thousand cycles; this limit only catches a hang
    initial begin
        #(8 * 20000);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
